/* File: core/accr_divider.sv */
// Input clock divider producing the sample enable pulse.
// Assumes ratio, clear and slip come from logic on ref_clk.
`timescale 1ns/10ps
module accr_divider
  import accr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input accr_ratio_t ratio,
  input wire logic sync_clr,
  input wire logic slip,
  output logic sample_en
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] last;
  logic at_last;

  // ---------------------------------------------------------------
  // Count decode
  // ---------------------------------------------------------------
  assign last = ratio_last(ratio);
  assign at_last = (cnt_q >= last);
  // A slip holds the count one input cycle, moving the phase by one
  assign cnt_d = sync_clr ? 2'h0 :
                 slip ? cnt_q :
                 at_last ? 2'h0 : cnt_q + 2'h1;
  assign sample_en = at_last & ~slip & ~sync_clr;

  // Divider counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

/* File: core/accr_pipeline.sv */
// Fixed-latency conversion pipeline, one stage per sample enable.
// Assumes data and enable are on ref_clk.
`timescale 1ns/10ps
module accr_pipeline
  import accr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout
);

  logic [DATA_W-1:0] stage_q [PIPE_LATENCY];

  // ---------------------------------------------------------------
  // Shift chain
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PIPE_LATENCY; i++) begin
        stage_q[i] <= '0;
      end
    end else if (en) begin
      stage_q[0] <= din;
      for (int i = 1; i < PIPE_LATENCY; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  // Oldest stage is the output, a full latency after entry
  assign dout = stage_q[PIPE_LATENCY-1];

endmodule

/* File: core/accr_pkg.sv */
// Shared constants, types and decode functions of the calibration and
// reset control block. Assumes one 50 MHz sample clock for all users.
package accr_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int CAL_TIME_MS = 200;
  localparam int CAL_MAX_MS = 550;
  // Nominal calibration length in clock cycles
  localparam int unsigned CAL_CYCLES =
    (CAL_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int DLL_LOCK_NS = 52000;
  // Longest lock time rounds down, in sample periods at full rate
  localparam int DLL_LOCK_SAMPLES = DLL_LOCK_NS / CLK_PERIOD_NS;
  localparam int PIPE_LATENCY = 10;
  localparam logic [7:0] POR_HOLD_CYCLES = 8'h10;

  // ---------------------------------------------------------------
  // Data and register map
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam logic [DATA_W-1:0] CAL_PATTERN = 16'hCCCC;
  localparam logic [7:0] CAL_STATE_ADDR = 8'hB6;
  localparam logic [7:0] CLK_CFG_ADDR = 8'h72;
  localparam logic [7:0] REG_ZERO = 8'h00;
  localparam int CAL_DONE_BIT = 0;
  localparam int CFG_DLL_SLOW_BIT = 0;
  localparam int CFG_RATIO_LSB = 1;
  localparam int CFG_OVR_BIT = 3;
  localparam int CFG_SLIP_BIT = 4;

  // Divide ratio codes; 2'b11 is illegal and falls back to divide by one
  typedef enum logic [1:0] {
    ACCR_DIV1 = 2'b00,
    ACCR_DIV2 = 2'b01,
    ACCR_DIV4 = 2'b10
  } accr_ratio_t;

  // Tri-level pin as seen through its two comparators
  localparam logic [1:0] PIN_GND = 2'b00;
  localparam logic [1:0] PIN_FLOAT = 2'b01;
  localparam logic [1:0] PIN_HIGH = 2'b10;

  typedef enum logic [2:0] {
    ST_POR_WAIT = 3'b000,
    ST_POR_HOLD = 3'b001,
    ST_PIN_LOW = 3'b010,
    ST_CALIB = 3'b011,
    ST_RUN = 3'b100
  } accr_state_t;

  typedef struct packed {
    logic ovr_en;
    accr_ratio_t ovr_ratio;
    logic dll_slow_range;
  } accr_cfg_t;

  localparam accr_cfg_t CFG_RESET = '{1'b0, ACCR_DIV1, 1'b0};

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } accr_reg_req_t;

  // Tri-level pin decode
  function automatic accr_ratio_t pin_to_ratio(input logic [1:0] lvl);
    accr_ratio_t r;
    r = ACCR_DIV1;
    if (lvl == PIN_GND) r = ACCR_DIV2;
    else if (lvl == PIN_HIGH) r = ACCR_DIV4;
    return r;
  endfunction

  // Last count value of the divider for a ratio
  function automatic logic [1:0] ratio_last(input accr_ratio_t r);
    logic [1:0] l;
    l = 2'h0;
    if (r == ACCR_DIV2) l = 2'h1;
    else if (r == ACCR_DIV4) l = 2'h3;
    return l;
  endfunction

endpackage

/* File: core/accr_top.sv */
// Calibration, reset and sample clock control of a pipelined converter.
// Assumes pins come from outside the clock domain and the register
// request port from an on-chip serial decoder on ref_clk.
//
// Summary of operation
// - Samples leave the outputs ten sample cycles after conversion starts; here eleven, counting the output register.
// - Power-on reset starts calibration once both supplies are good.
// - Device holds the reset pin low during power-on, then releases it.
// - Calibration begins on the rising edge of the reset pin.
// - Status bit zero at 0xB6 reads zero while calibrating, one after.
// - Data outputs show 0xCCCC while calibration runs.
// - Output clock stays low while the reset pin is low.
// - Output clock resumes at the next sample edge after release.
// - Calibration takes 200 ms nominal, never beyond 550 ms.
// - Divider select pin: ground two, floating one, high four.
// - A register-written divide ratio overrides the select pin.
// - Delay-locked loop relocks within 52 us, scaling with sample rate.
// - Loop has slow range 40-100 MSPS and default fast range above.
// - Phase slip aligns converters while the divider is active.
// - Output clock runs at half the sample rate.
`timescale 1ns/10ps
module accr_top
  import accr_pkg::*;
#(
  parameter int unsigned CAL_CYCLES_P = CAL_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic analog_supply_ok,
  input wire logic digital_supply_ok,
  input wire logic calibrate_reset_n_in,
  output logic calibrate_reset_n_out,
  output logic calibrate_reset_n_oe,
  input wire logic [1:0] divider_select_pin,
  input wire logic divider_sync_reset,
  input accr_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [DATA_W-1:0] conv_data,
  output logic [DATA_W-1:0] data_out,
  output logic output_clock_pair_p,
  output logic output_clock_pair_n,
  output logic cal_done,
  output logic dll_locked,
  output logic dll_fast_range
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sup_s1_q;
  logic [1:0] sup_s2_q;
  logic rpin_s1_q;
  logic rpin_s2_q;
  logic rpin_s3_q;
  logic [1:0] sel_s1_q;
  logic [1:0] sel_s2_q;
  logic dsr_s1_q;
  logic dsr_s2_q;
  logic dsr_s3_q;

  // Two flops per pin; the third flops only feed edge detectors
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_s1_q <= 2'h0;
      sup_s2_q <= 2'h0;
      rpin_s1_q <= 1'b0;
      rpin_s2_q <= 1'b0;
      rpin_s3_q <= 1'b0;
      sel_s1_q <= PIN_FLOAT;
      sel_s2_q <= PIN_FLOAT;
      dsr_s1_q <= 1'b0;
      dsr_s2_q <= 1'b0;
      dsr_s3_q <= 1'b0;
    end else begin
      sup_s1_q <= {analog_supply_ok, digital_supply_ok};
      sup_s2_q <= sup_s1_q;
      rpin_s1_q <= calibrate_reset_n_in;
      rpin_s2_q <= rpin_s1_q;
      rpin_s3_q <= rpin_s2_q;
      sel_s1_q <= divider_select_pin;
      sel_s2_q <= sel_s1_q;
      dsr_s1_q <= divider_sync_reset;
      dsr_s2_q <= dsr_s1_q;
      dsr_s3_q <= dsr_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // Decode of pins and register requests
  // ---------------------------------------------------------------
  accr_state_t state_q;
  accr_state_t state_d;
  accr_cfg_t cfg_q;
  logic por_cal_q;
  logic cal_done_q;
  logic [7:0] hold_cnt_q;
  logic [31:0] cal_cnt_q;
  logic supplies_ok;
  logic pin_low;
  logic pin_rise;
  logic sync_rise;
  logic hold_done;
  logic cal_end;
  logic cfg_hit;
  logic cfg_wr;
  logic slip;
  logic sample_en;
  accr_ratio_t ratio;
  accr_ratio_t ratio_prev_q;
  logic [7:0] rd_word;

  // Supplies must both be good before calibration may start
  assign supplies_ok = &sup_s2_q;
  assign pin_low = ~rpin_s2_q;
  assign pin_rise = rpin_s2_q & ~rpin_s3_q;
  assign sync_rise = dsr_s2_q & ~dsr_s3_q;
  assign hold_done = (hold_cnt_q == POR_HOLD_CYCLES - 8'h01);
  assign cal_end = (cal_cnt_q == CAL_CYCLES_P - 32'd1);

  // Register written ratio wins over the select pin
  assign ratio = cfg_q.ovr_en ? cfg_q.ovr_ratio :
                 pin_to_ratio(sel_s2_q);

  // Writes during power-on calibration are dropped, not queued
  assign cfg_hit = (reg_req.addr == CLK_CFG_ADDR);
  assign cfg_wr = reg_req.wr_en & cfg_hit & ~por_cal_q;
  // Slip only means something while a divide ratio is in force
  assign slip = cfg_wr & reg_req.wdata[CFG_SLIP_BIT] &
                (ratio != ACCR_DIV1);

  // Read data selection; unmapped addresses read zero
  assign rd_word =
    (reg_req.addr == CAL_STATE_ADDR) ?
      {7'h00, cal_done_q} :
    cfg_hit ? {4'h0, cfg_q} : REG_ZERO;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Pin low forces a restart from any running state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_POR_WAIT: begin
        if (supplies_ok) state_d = ST_POR_HOLD;
      end
      ST_POR_HOLD: begin
        if (hold_done) state_d = ST_PIN_LOW;
      end
      ST_PIN_LOW: begin
        if (pin_rise) state_d = ST_CALIB;
      end
      ST_CALIB: begin
        if (pin_low) state_d = ST_PIN_LOW;
        else if (cal_end) state_d = ST_RUN;
      end
      ST_RUN: begin
        if (pin_low) state_d = ST_PIN_LOW;
      end
      default: state_d = ST_POR_WAIT;
    endcase
  end

  // State and counters
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_POR_WAIT;
      hold_cnt_q <= 8'h00;
      cal_cnt_q <= 32'd0;
    end else begin
      state_q <= state_d;
      hold_cnt_q <= (state_q == ST_POR_HOLD) ?
                    hold_cnt_q + 8'h01 : 8'h00;
      cal_cnt_q <= (state_q == ST_CALIB && !pin_low) ?
                   cal_cnt_q + 32'd1 : 32'd0;
    end
  end

  // Done flag: cleared by the pin, set only when counting completes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_done_q <= 1'b0;
      por_cal_q <= 1'b1;
    end else begin
      if (pin_low) cal_done_q <= 1'b0;
      else if (state_q == ST_CALIB && cal_end) cal_done_q <= 1'b1;
      if (state_q == ST_RUN) por_cal_q <= 1'b0;
    end
  end

  // Device pulls the shared reset pin low only during power-on
  assign calibrate_reset_n_out = 1'b0;
  assign calibrate_reset_n_oe = (state_q == ST_POR_WAIT) ||
                                (state_q == ST_POR_HOLD);

  // ---------------------------------------------------------------
  // Configuration and read-back registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
      reg_rdata <= REG_ZERO;
    end else begin
      if (cfg_wr) begin
        cfg_q.ovr_en <= reg_req.wdata[CFG_OVR_BIT];
        cfg_q.ovr_ratio <=
          accr_ratio_t'(reg_req.wdata[CFG_RATIO_LSB +: 2]);
        cfg_q.dll_slow_range <= reg_req.wdata[CFG_DLL_SLOW_BIT];
      end
      if (reg_req.rd_en) reg_rdata <= rd_word;
    end
  end

  assign cal_done = cal_done_q;
  // Fast range is the reset default; slow range by register
  assign dll_fast_range = ~cfg_q.dll_slow_range;

  // ---------------------------------------------------------------
  // Sample clock divider and lock tracking
  // ---------------------------------------------------------------
  accr_divider u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ratio(ratio),
    .sync_clr(sync_rise),
    .slip(slip),
    .sample_en(sample_en)
  );

  logic [11:0] lock_cnt_q;
  logic relock;
  logic lock_reached;

  // Any ratio change or divider resync restarts the lock wait
  assign relock = (ratio != ratio_prev_q) | sync_rise;
  // Counted in sample periods, so slower rates lock later in time
  assign lock_reached = (lock_cnt_q == 12'(DLL_LOCK_SAMPLES));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ratio_prev_q <= ACCR_DIV1;
      lock_cnt_q <= 12'h000;
    end else begin
      ratio_prev_q <= ratio;
      if (relock) lock_cnt_q <= 12'h000;
      else if (sample_en && !lock_reached) lock_cnt_q <= lock_cnt_q + 12'h001;
    end
  end

  assign dll_locked = lock_reached & ~relock;

  // ---------------------------------------------------------------
  // Data path and output clock
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] pipe_out;
  logic [DATA_W-1:0] data_q;
  logic oclk_p_q;
  logic oclk_n_q;
  logic oclk_run;

  accr_pipeline u_pipe (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(sample_en),
    .din(conv_data),
    .dout(pipe_out)
  );

  // Pattern instead of samples until calibration has finished
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= CAL_PATTERN;
    end else if (sample_en) begin
      data_q <= (state_q == ST_RUN) ? pipe_out : CAL_PATTERN;
    end
  end

  assign data_out = data_q;

  // Clock runs in calibration and normal operation, held low otherwise
  assign oclk_run = ~pin_low &&
    (state_q == ST_CALIB || state_q == ST_RUN);

  // Toggle per sample gives half the sample rate; resync sets phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oclk_p_q <= 1'b0;
      oclk_n_q <= 1'b1;
    end else if (!oclk_run || sync_rise) begin
      oclk_p_q <= 1'b0;
      oclk_n_q <= 1'b1;
    end else if (sample_en) begin
      oclk_p_q <= ~oclk_p_q;
      oclk_n_q <= oclk_p_q;
    end
  end

  assign output_clock_pair_p = oclk_p_q;
  assign output_clock_pair_n = oclk_n_q;

endmodule

/* File: dv/accr_host_model.sv */
// Host side of the reset pin: open-drain puller over a pull-up.
// Assumes the bench pulses recal_req for one cycle per request.
`timescale 1ns/10ps
module accr_host_model (
  input wire logic ref_clk,
  input wire logic recal_req,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic pin_level
);
  logic [2:0] low_cnt_q = 3'h0;

  // Hold low four cycles; one cycle could slip past the synchroniser
  always_ff @(posedge ref_clk) begin
    if (recal_req)
      low_cnt_q <= 3'h4;
    else if (low_cnt_q != 3'h0)
      low_cnt_q <= low_cnt_q - 3'h1;
  end

  // Wired-AND of both pullers, high by the pull-up otherwise
  assign pin_level =
    !((dev_oe && !dev_out) || low_cnt_q != 3'h0);
endmodule

/* File: dv/accr_top_props.sv */
// Port checker for the calibration and reset control block.
// Assumes it is bound to accr_top with the same calibration length.
`timescale 1ns/10ps
module accr_top_props
  import accr_pkg::*;
#(
  parameter int unsigned CAL_CYCLES_P = CAL_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic analog_supply_ok,
  input wire logic digital_supply_ok,
  input wire logic calibrate_reset_n_in,
  input wire logic calibrate_reset_n_out,
  input wire logic calibrate_reset_n_oe,
  input wire logic [1:0] divider_select_pin,
  input wire logic divider_sync_reset,
  input accr_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic [DATA_W-1:0] conv_data,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic output_clock_pair_p,
  input wire logic output_clock_pair_n,
  input wire logic cal_done,
  input wire logic dll_locked,
  input wire logic dll_fast_range
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ------
  // Helper counters
  // ------
  logic [31:0] hi_cnt_q;
  logic [31:0] same_cnt_q;
  logic clk_q;

  // Run length of a high pin, and cycles since the clock last moved
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_q <= '0;
      same_cnt_q <= '0;
      clk_q <= 1'b0;
    end else begin
      hi_cnt_q <= calibrate_reset_n_in ? hi_cnt_q + 32'h1 : '0;
      same_cnt_q <= (output_clock_pair_p != clk_q) ? '0 : same_cnt_q + 32'h1;
      clk_q <= output_clock_pair_p;
    end
  end

  // ------
  // Properties
  // ------
  // Four samples of slack cover the two-flop pin synchroniser
  property p_clk_low;
    !calibrate_reset_n_in [*4] |-> !output_clock_pair_p && output_clock_pair_n;
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("output clock not held low");
  property p_done_clear;
    !calibrate_reset_n_in [*4] |-> !cal_done;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done flag not cleared");
  property p_pattern;
    !cal_done && $past(!cal_done) |-> data_out == CAL_PATTERN;
  endproperty
  a_pattern: assert property (p_pattern)
    else $error("pattern missing");
  property p_status;
    reg_req.rd_en && reg_req.addr == CAL_STATE_ADDR
      |=> reg_rdata == {7'h00, $past(cal_done)};
  endproperty
  a_status: assert property (p_status)
    else $error("status read wrong");
  property p_done_min;
    $rose(cal_done) |-> hi_cnt_q >= CAL_CYCLES_P;
  endproperty
  a_done_min: assert property (p_done_min)
    else $error("calibration too short");
  property p_done_max;
    hi_cnt_q == CAL_CYCLES_P + 8 |-> cal_done;
  endproperty
  a_done_max: assert property (p_done_max)
    else $error("calibration too long");
  property p_oe_rel;
    $fell(calibrate_reset_n_oe)
      |-> $past(analog_supply_ok, 16) && $past(digital_supply_ok, 16);
  endproperty
  a_oe_rel: assert property (p_oe_rel)
    else $error("pin released early");
  property p_pair;
    output_clock_pair_p != output_clock_pair_n;
  endproperty
  a_pair: assert property (p_pair)
    else $error("clock pair not complementary");
  property p_clk_runs;
    cal_done && calibrate_reset_n_in |-> same_cnt_q < 32'd6;
  endproperty
  a_clk_runs: assert property (p_clk_runs)
    else $error("output clock stalled");
endmodule

/* File: dv/accr_top_test.sv */
// Self-checking bench of the calibration and reset control block.
// Assumes the host model on the reset pin and a short calibration.
`timescale 1ns/10ps
module accr_top_test;
  import accr_pkg::*;
  localparam int unsigned CAL_N = 50;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic analog_supply_ok = 1'b0;
  logic digital_supply_ok = 1'b0;
  logic calibrate_reset_n_in, oe, od_out;
  logic recal_req = 1'b0;
  logic [1:0] div_pin = PIN_FLOAT;
  logic div_rst = 1'b0;
  accr_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata, rd;
  logic [DATA_W-1:0] conv_data = '0;
  logic [DATA_W-1:0] data_out;
  logic clk_p, clk_n, cal_done, dll_locked, dll_fast;
  int error_cnt = 0;
  int n_checks = 0;
  int tog;
  logic [DATA_W-1:0] hist[$];
  logic [1:0] lvls[4] = '{PIN_GND, PIN_FLOAT, PIN_HIGH, 2'b11};

  // Steady sample clock throughout
  always #10 ref_clk = ~ref_clk;

  accr_top #(.CAL_CYCLES_P(CAL_N)) u_accr_top (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .analog_supply_ok(analog_supply_ok),
    .digital_supply_ok(digital_supply_ok),
    .calibrate_reset_n_in(calibrate_reset_n_in),
    .calibrate_reset_n_out(od_out), .calibrate_reset_n_oe(oe),
    .divider_select_pin(div_pin), .divider_sync_reset(div_rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata),
    .conv_data(conv_data), .data_out(data_out),
    .output_clock_pair_p(clk_p), .output_clock_pair_n(clk_n),
    .cal_done(cal_done), .dll_locked(dll_locked),
    .dll_fast_range(dll_fast)
  );

  accr_host_model u_accr_host_model (
    .ref_clk(ref_clk), .recal_req(recal_req), .dev_oe(oe),
    .dev_out(od_out), .pin_level(calibrate_reset_n_in)
  );

  // ------
  // Tasks and expectations
  // ------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One-cycle request pulses; read data lands one edge later
  task automatic reg_acc(input logic w, input logic [7:0] a,
                         input logic [7:0] v);
    @(negedge ref_clk);
    reg_req = '{!w, w, a, v};
    @(negedge ref_clk);
    reg_req = '0;
    rd = reg_rdata;
  endtask

  task automatic wait_done();
    for (int i = 0; i < CAL_N + 100 && cal_done !== 1'b1; i++)
      @(negedge ref_clk);
    if (cal_done !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  // Toggles over 40 cycles once the new ratio has settled
  task automatic count_toggles();
    logic last;
    repeat (8) @(negedge ref_clk);
    last = clk_p;
    tog = 0;
    repeat (40) begin
      @(negedge ref_clk);
      if (clk_p !== last) tog++;
      last = clk_p;
    end
  endtask

  // Input cycles between output clock edges across one phase slip
  task automatic slip_gap();
    logic last;
    last = clk_p;
    for (int i = 0; i < 8 && clk_p === last; i++)
      @(negedge ref_clk);
    last = clk_p;
    reg_acc(1'b1, CLK_CFG_ADDR, 8'h1B);
    tog = 2;
    while (tog < 8 && clk_p === last) begin
      @(negedge ref_clk);
      tog++;
    end
  endtask

  function automatic logic [15:0] exp_tog(input logic [1:0] lvl);
    return (lvl == PIN_GND) ? 16'd20 : (lvl == PIN_HIGH) ? 16'd10 : 16'd40;
  endfunction

  // ------
  // Main sequence
  // ------
  initial begin
    void'($urandom(40));
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    // Supplies come late so the hold is seen before them
    repeat (4) @(negedge ref_clk);
    chk(oe, 1'b1);
    analog_supply_ok = 1'b1;
    digital_supply_ok = 1'b1;
    // Accesses kept inside the power-on hold, before calibration
    reg_acc(1'b0, CAL_STATE_ADDR, 8'h00);
    chk(rd, 8'h00);
    reg_acc(1'b1, CLK_CFG_ADDR, 8'h0C);
    chk(data_out, CAL_PATTERN);
    wait_done();
    reg_acc(1'b0, CAL_STATE_ADDR, 8'h00);
    chk(rd, 8'h01);
    reg_acc(1'b0, CLK_CFG_ADDR, 8'h00);
    chk(rd, 8'h00);
    reg_acc(1'b0, 8'h10, 8'h00);
    chk(rd, REG_ZERO);
    foreach (lvls[i]) begin
      div_pin = lvls[i];
      count_toggles();
      chk(16'(tog), exp_tog(lvls[i]));
    end
    div_pin = PIN_FLOAT;
    reg_acc(1'b1, CLK_CFG_ADDR, 8'h0C);
    count_toggles();
    chk(16'(tog), 16'd10);
    reg_acc(1'b1, CLK_CFG_ADDR, 8'h0B);
    reg_acc(1'b0, CLK_CFG_ADDR, 8'h00);
    chk(rd, 8'h0B);
    chk(dll_fast, 1'b0);
    count_toggles();
    chk(16'(tog), 16'd20);
    // Slip at divide by two: one gap grows from two to three cycles
    slip_gap();
    chk(16'(tog), 16'd3);
    reg_acc(1'b0, CLK_CFG_ADDR, 8'h00);
    chk(rd, 8'h0B);
    reg_acc(1'b1, CLK_CFG_ADDR, 8'h00);
    chk(dll_fast, 1'b1);
    // Lock needs 2600 samples at divide by one
    repeat (2500) @(negedge ref_clk);
    chk(dll_locked, 1'b0);
    for (int i = 0; i < 200 && dll_locked !== 1'b1; i++)
      @(negedge ref_clk);
    chk(dll_locked, 1'b1);
    div_rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(dll_locked, 1'b0);
    div_rst = 1'b0;
    // Random words through the pipeline at divide by one
    repeat (40) begin
      @(negedge ref_clk);
      if (hist.size() > 12)
        chk(data_out, hist[hist.size()-11]);
      conv_data = DATA_W'($urandom);
      @(posedge ref_clk);
      hist.push_back(conv_data);
    end
    // Recalibration pulse from the host
    repeat ($urandom % 5) @(negedge ref_clk);
    recal_req = 1'b1;
    @(negedge ref_clk);
    recal_req = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(cal_done, 1'b0);
    chk({clk_p, clk_n}, 2'b01);
    chk(data_out, CAL_PATTERN);
    wait_done();
    reg_acc(1'b0, CAL_STATE_ADDR, 8'h00);
    chk(rd, 8'h01);
    give_verdict();
  end
endmodule

bind accr_top accr_top_props #(.CAL_CYCLES_P(CAL_CYCLES_P)) u_accr_top_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .analog_supply_ok(analog_supply_ok),
  .digital_supply_ok(digital_supply_ok),
  .calibrate_reset_n_in(calibrate_reset_n_in),
  .calibrate_reset_n_out(calibrate_reset_n_out),
  .calibrate_reset_n_oe(calibrate_reset_n_oe),
  .divider_select_pin(divider_select_pin),
  .divider_sync_reset(divider_sync_reset), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .conv_data(conv_data), .data_out(data_out),
  .output_clock_pair_p(output_clock_pair_p),
  .output_clock_pair_n(output_clock_pair_n), .cal_done(cal_done),
  .dll_locked(dll_locked), .dll_fast_range(dll_fast_range)
);
